/* File: rtl/wdog_pkg.sv */
package wdog_pkg;

  // ----------------------------------------
  // register map, byte addresses
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_RELOAD_HOLDING = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_LIVE_COUNT = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_CONTROL_GATES = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ACKNOWLEDGE = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_RAW_IRQ_FLAG = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_GATED_IRQ_FLAG = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_WRITE_PROTECTION = 12'hC00;

  // ----------------------------------------
  // field positions, reset values, keys
  // ----------------------------------------
  localparam logic [31:0] RELOAD_RESET = 32'h0FFF_FFFF;
  localparam int BIT_IRQ_GATE = 0;
  localparam int BIT_REBOOT_GATE = 1;
  localparam logic [31:0] WRITE_GUARD_KEY = 32'h1ACC_E551;

endpackage

/* File: rtl/wdog_tick_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// low-speed timebase: synchronise and edge detect
// ----------------------------------------
module wdog_tick_sync (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ls_clk,
  output logic tick
);

  logic meta_q;
  logic sync_q;
  logic prev_q;
  logic tick_q;

  // meta_q feeds only sync_q
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= ls_clk;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // one core cycle per rising timebase edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= sync_q & ~prev_q;
    end
  end

  assign tick = tick_q;

endmodule

`default_nettype wire

/* File: rtl/watchdog_countdown_timer.sv */
`timescale 1ns/1ps
`default_nettype none

//
// Contract
// - 32-bit counter decrements once per timebase tick
// - interrupt period equals reload plus one ticks
// - at zero set flag and reload counter in the same cycle
// - acknowledge also reloads counter from reload value
// - zero while flag set resets, if enabled
// - disabled halts counter; enabling restarts from reload
// - key unlocks writes; other value blocks them
// - reload write stores and restarts counting immediately
// - live count reads counter; writes ignored
// - control bit 0 gates interrupt, resets 0
// - control bit 1 gates reset output, resets 0
// - acknowledge write of any value clears flag, unless a zero lands in the same cycle; reads zero
// - raw flag bit 0, read-only
// - gated flag is raw and interrupt gate
// - protection read returns 1 when blocked
module watchdog_countdown_timer (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic ls_clk,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  output logic irq,
  output logic sys_reset_req
);

  // ----------------------------------------
  // reset release and timebase
  // ----------------------------------------
  logic rst_meta_q;
  logic rst_n;
  logic tick;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  wdog_tick_sync u_tick (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ls_clk(ls_clk),
    .tick(tick)
  );

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [31:0] reload_holding_q;
  logic [31:0] live_count_q;
  logic irq_gate_q;
  logic reboot_gate_q;
  logic raw_irq_flag_q;
  logic locked_q;
  logic reset_req_q;
  logic [31:0] rdata_q;

  logic wr_ok;
  logic wr_reload;
  logic wr_ctrl;
  logic wr_ack;
  logic enable_rise;
  logic zero_evt;
  logic gated_irq_flag;

  // protection register itself is always writable
  assign wr_ok = wr_en & ~locked_q;
  assign wr_reload = wr_ok && addr == wdog_pkg::OFS_RELOAD_HOLDING;
  assign wr_ctrl = wr_ok && addr == wdog_pkg::OFS_CONTROL_GATES;
  assign wr_ack = wr_ok && addr == wdog_pkg::OFS_IRQ_ACKNOWLEDGE;
  assign enable_rise = wr_ctrl & wdata[wdog_pkg::BIT_IRQ_GATE] & ~irq_gate_q;
  assign zero_evt = tick & irq_gate_q & (live_count_q == 32'h0000_0000);
  assign gated_irq_flag = raw_irq_flag_q & irq_gate_q;

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reload_holding_q <= wdog_pkg::RELOAD_RESET;
    end else if (wr_reload) begin
      reload_holding_q <= wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_gate_q <= 1'b0;
      reboot_gate_q <= 1'b0;
    end else if (wr_ctrl) begin
      irq_gate_q <= wdata[wdog_pkg::BIT_IRQ_GATE];
      reboot_gate_q <= wdata[wdog_pkg::BIT_REBOOT_GATE];
    end
  end

  // reset value 0 reads as unlocked
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      locked_q <= 1'b0;
    end else if (wr_en && addr == wdog_pkg::OFS_WRITE_PROTECTION) begin
      locked_q <= (wdata != wdog_pkg::WRITE_GUARD_KEY);
    end
  end

  // ----------------------------------------
  // countdown
  // ----------------------------------------
  // reload-then-zero spans reload+1 ticks
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      live_count_q <= wdog_pkg::RELOAD_RESET;
    end else if (wr_reload) begin
      live_count_q <= wdata;
    end else if (enable_rise || wr_ack) begin
      live_count_q <= reload_holding_q;
    end else if (zero_evt) begin
      live_count_q <= reload_holding_q;
    end else if (tick && irq_gate_q) begin
      live_count_q <= live_count_q - 32'h0000_0001;
    end
  end

  // a zero in the cycle of an acknowledge keeps the flag set
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      raw_irq_flag_q <= 1'b0;
    end else if (zero_evt) begin
      raw_irq_flag_q <= 1'b1;
    end else if (wr_ack) begin
      raw_irq_flag_q <= 1'b0;
    end
  end

  // an acknowledge in the same cycle counts as served
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_req_q <= 1'b0;
    end else begin
      reset_req_q <= zero_evt & raw_irq_flag_q & ~wr_ack & reboot_gate_q;
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_en) begin
      unique case (addr)
        wdog_pkg::OFS_RELOAD_HOLDING: rdata_q <= reload_holding_q;
        wdog_pkg::OFS_LIVE_COUNT: rdata_q <= live_count_q;
        wdog_pkg::OFS_CONTROL_GATES: rdata_q <= {30'h0000_0000, reboot_gate_q, irq_gate_q};
        wdog_pkg::OFS_RAW_IRQ_FLAG: rdata_q <= {31'h0000_0000, raw_irq_flag_q};
        wdog_pkg::OFS_GATED_IRQ_FLAG: rdata_q <= {31'h0000_0000, gated_irq_flag};
        wdog_pkg::OFS_WRITE_PROTECTION: rdata_q <= {31'h0000_0000, locked_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign rdata = rdata_q;
  assign irq = gated_irq_flag;
  assign sys_reset_req = reset_req_q;

  // ----------------------------------------
  // period monitor for assertions
  // ----------------------------------------
  // ticks since the last restart; one bit wider so reload plus one fits
  logic [32:0] period_ticks_q;
  logic restart_evt;

  assign restart_evt = wr_reload | enable_rise | wr_ack | zero_evt;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      period_ticks_q <= 33'h0_0000_0000;
    end else if (restart_evt) begin
      period_ticks_q <= 33'h0_0000_0000;
    end else if (tick && irq_gate_q) begin
      period_ticks_q <= period_ticks_q + 33'h0_0000_0001;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_count_decrement: assert property (tick && irq_gate_q && live_count_q != 32'h0000_0000 && !wr_en
    |=> live_count_q == $past(live_count_q) - 32'h0000_0001)
    else $error("counter did not step down on tick");

  a_zero_reload: assert property (zero_evt && !wr_en |=> live_count_q == $past(reload_holding_q))
    else $error("counter not reloaded at zero");

  a_zero_flag: assert property (zero_evt |=> raw_irq_flag_q)
    else $error("flag not set at zero");

  a_ack_reload: assert property (wr_ack && !zero_evt |=> !raw_irq_flag_q && live_count_q == $past(reload_holding_q))
    else $error("acknowledge did not clear and reload");

  a_reset_pulse: assert property (zero_evt && raw_irq_flag_q && !wr_ack && reboot_gate_q
    |=> sys_reset_req ##1 !sys_reset_req)
    else $error("reset pulse missing or too long");

  a_reset_gated: assert property (!reboot_gate_q |=> !sys_reset_req)
    else $error("reset issued while gated off");

  a_halt_count: assert property (!irq_gate_q && !wr_en |=> $stable(live_count_q))
    else $error("counter moved while disabled");

  a_enable_restart: assert property ($rose(irq_gate_q) |-> live_count_q == reload_holding_q)
    else $error("enable did not restart from reload");

  a_locked_ctrl: assert property (locked_q && wr_en && addr == wdog_pkg::OFS_CONTROL_GATES
    |=> $stable(irq_gate_q) && $stable(reboot_gate_q))
    else $error("control changed while write protected");

  a_reload_write: assert property (wr_reload |=> live_count_q == $past(wdata) && reload_holding_q == $past(wdata))
    else $error("reload write not applied");

  a_live_read: assert property (rd_en && addr == wdog_pkg::OFS_LIVE_COUNT |=> rdata == $past(live_count_q))
    else $error("live count read mismatch");

  a_ack_read_zero: assert property (rd_en && addr == wdog_pkg::OFS_IRQ_ACKNOWLEDGE |=> rdata == 32'h0000_0000)
    else $error("acknowledge register read nonzero");

  a_gated_read: assert property (rd_en && addr == wdog_pkg::OFS_GATED_IRQ_FLAG
    |=> rdata == {31'h0000_0000, $past(raw_irq_flag_q & irq_gate_q)})
    else $error("gated flag read mismatch");

  a_guard_read: assert property (rd_en && addr == wdog_pkg::OFS_WRITE_PROTECTION
    |=> rdata == {31'h0000_0000, $past(locked_q)})
    else $error("protection status read mismatch");

  a_period_length: assert property (zero_evt
    |-> period_ticks_q == {1'b0, reload_holding_q})
    else $error("interrupt period differs from reload plus one");

  a_irq_output: assert property (irq_gate_q
    |-> irq == raw_irq_flag_q)
    else $error("interrupt line differs from flag");

  a_irq_masked: assert property (!irq_gate_q
    |-> !irq)
    else $error("interrupt line high while gated off");

  a_flag_hold: assert property (raw_irq_flag_q && !wr_ack
    |=> raw_irq_flag_q)
    else $error("flag dropped without acknowledge");

  a_flag_quiet: assert property (!raw_irq_flag_q && !zero_evt
    |=> !raw_irq_flag_q)
    else $error("flag set without zero");

  a_locked_reload: assert property (locked_q && wr_en && addr == wdog_pkg::OFS_RELOAD_HOLDING
    |=> $stable(reload_holding_q))
    else $error("reload changed while write protected");

  a_locked_ack: assert property (raw_irq_flag_q && locked_q && wr_en
    && addr == wdog_pkg::OFS_IRQ_ACKNOWLEDGE |=> raw_irq_flag_q)
    else $error("acknowledge taken while write protected");

  a_unlock_key: assert property (wr_en && addr == wdog_pkg::OFS_WRITE_PROTECTION
    && wdata == wdog_pkg::WRITE_GUARD_KEY |=> !locked_q)
    else $error("key did not unlock");

  a_lock_other: assert property (wr_en && addr == wdog_pkg::OFS_WRITE_PROTECTION
    && wdata != wdog_pkg::WRITE_GUARD_KEY |=> locked_q)
    else $error("other value did not lock");

  a_live_ignore: assert property (wr_en && addr == wdog_pkg::OFS_LIVE_COUNT && !tick
    |=> $stable(live_count_q))
    else $error("live count took a write");

  a_ctrl_read: assert property (rd_en && addr == wdog_pkg::OFS_CONTROL_GATES
    |=> rdata == {30'h0000_0000, $past(reboot_gate_q), $past(irq_gate_q)})
    else $error("control read mismatch");

  a_raw_read: assert property (rd_en && addr == wdog_pkg::OFS_RAW_IRQ_FLAG
    |=> rdata == {31'h0000_0000, $past(raw_irq_flag_q)})
    else $error("raw flag read mismatch");

  a_reload_read: assert property (rd_en && addr == wdog_pkg::OFS_RELOAD_HOLDING
    |=> rdata == $past(reload_holding_q))
    else $error("reload read mismatch");

  a_raw_ignore: assert property (wr_en && addr == wdog_pkg::OFS_RAW_IRQ_FLAG && !zero_evt
    |=> raw_irq_flag_q == $past(raw_irq_flag_q))
    else $error("raw flag took a write");

  a_ctrl_write: assert property (wr_ctrl
    |=> irq_gate_q == $past(wdata[wdog_pkg::BIT_IRQ_GATE]))
    else $error("interrupt gate write not applied");

  a_ctrl_reboot: assert property (wr_ctrl
    |=> reboot_gate_q == $past(wdata[wdog_pkg::BIT_REBOOT_GATE]))
    else $error("reset gate write not applied");

  a_reset_cause: assert property (sys_reset_req
    |-> $past(zero_evt) && $past(raw_irq_flag_q) && $past(reboot_gate_q))
    else $error("reset request without unserved zero");

  a_reset_single: assert property (sys_reset_req
    |=> !sys_reset_req)
    else $error("reset request longer than one cycle");

  a_ack_no_reset: assert property (wr_ack
    |=> !sys_reset_req)
    else $error("reset issued despite acknowledge");

  a_enable_load: assert property (enable_rise
    |=> live_count_q == $past(reload_holding_q))
    else $error("enable did not load reload value");

  a_disable_freeze: assert property (wr_ctrl && !wdata[wdog_pkg::BIT_IRQ_GATE] && !tick
    |=> $stable(live_count_q))
    else $error("counter moved on disable");

  a_tick_spacing: assert property (tick
    |=> !tick)
    else $error("timebase tick longer than one cycle");

  c_zero_event: cover property (zero_evt);
  c_reset_issued: cover property (sys_reset_req);
  c_unlock_then_reload: cover property (locked_q ##1 !locked_q ##[1:20] wr_reload);
  c_ack_served: cover property (raw_irq_flag_q ##1 wr_ack ##1 !raw_irq_flag_q);

endmodule

`default_nettype wire

/* File: tb/reset_sink.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// far side: interrupt input and reset controller
// ----------------------------------------
module reset_sink (
  input wire logic core_clk,
  input wire logic irq,
  input wire logic sys_reset_req,
  output var int reset_cycles,
  output var int orphan_resets
);
  // counts high cycles, so a stretched pulse shows up as more than one
  initial reset_cycles = 0;
  initial orphan_resets = 0;
  always @(posedge core_clk) begin
    if (sys_reset_req === 1'b1) begin
      reset_cycles <= reset_cycles + 1;
    end
    // a reset is only due while the interrupt stands unserved
    if (sys_reset_req === 1'b1 && irq !== 1'b1) begin
      orphan_resets <= orphan_resets + 1;
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// watchdog bench
// ----------------------------------------
module tb;
  localparam logic [11:0] r_ld = wdog_pkg::OFS_RELOAD_HOLDING;
  localparam logic [11:0] r_lc = wdog_pkg::OFS_LIVE_COUNT;
  localparam logic [11:0] r_ctl = wdog_pkg::OFS_CONTROL_GATES;
  localparam logic [11:0] r_ack = wdog_pkg::OFS_IRQ_ACKNOWLEDGE;
  localparam logic [11:0] r_raw = wdog_pkg::OFS_RAW_IRQ_FLAG;
  localparam logic [11:0] r_msk = wdog_pkg::OFS_GATED_IRQ_FLAG;
  localparam logic [11:0] r_prot = wdog_pkg::OFS_WRITE_PROTECTION;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic ls_clk = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rdata;
  logic irq;
  logic sys_reset_req;
  int reset_cycles;
  int orphan_resets;
  int fails = 0;
  int n_compared = 0;
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  watchdog_countdown_timer i_dut (.core_clk(core_clk), .arst_n(arst_n), .ls_clk(ls_clk), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq), .sys_reset_req(sys_reset_req));
  reset_sink i_sink (.core_clk(core_clk), .irq(irq), .sys_reset_req(sys_reset_req),
    .reset_cycles(reset_cycles), .orphan_resets(orphan_resets));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  // timebase edges far apart, as the synchroniser needs
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge core_clk);
      ls_clk <= 1'b1;
      repeat (8) @(posedge core_clk);
      ls_clk <= 1'b0;
      repeat (8) @(posedge core_clk);
    end
  endtask
  task automatic t_reset();
    rd(r_ld, 32'h0FFF_FFFF);
    rd(r_lc, 32'h0FFF_FFFF);
    rd(r_ctl, 32'h0000_0000);
    rd(r_ack, 32'h0000_0000);
    rd(r_raw, 32'h0000_0000);
    rd(r_msk, 32'h0000_0000);
    rd(r_prot, 32'h0000_0000);
    rd(12'h020, 32'h0000_0000);
    $display("reset test done");
  endtask
  task automatic t_count();
    wr(r_ctl, 32'h0000_0001);
    wr(r_ld, 32'h0000_0003);
    tick(1);
    rd(r_lc, 32'h0000_0002);
    wr(r_lc, 32'h0000_0009);
    rd(r_lc, 32'h0000_0002);
    tick(2);
    rd(r_raw, 32'h0000_0000);
    tick(1);
    rd(r_raw, 32'h0000_0001);
    rd(r_lc, 32'h0000_0003);
    rd(r_msk, 32'h0000_0001);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    wr(r_raw, 32'h0000_0000);
    rd(r_raw, 32'h0000_0001);
    $display("count test done");
  endtask
  task automatic t_ack();
    tick(1);
    wr(r_ack, 32'hDEAD_BEEF);
    rd(r_raw, 32'h0000_0000);
    rd(r_lc, 32'h0000_0003);
    rd(r_ack, 32'h0000_0000);
    $display("ack test done");
  endtask
  task automatic t_gate();
    tick(5);
    wr(r_ctl, 32'h0000_0000);
    rd(r_msk, 32'h0000_0000);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    rd(r_raw, 32'h0000_0001);
    tick(2);
    rd(r_lc, 32'h0000_0002);
    wr(r_ctl, 32'hFFFF_FFFD);
    rd(r_ctl, 32'h0000_0001);
    rd(r_lc, 32'h0000_0003);
    wr(r_ack, 32'h0000_0000);
    $display("gate test done");
  endtask
  task automatic t_lock();
    wr(r_prot, 32'h1234_5678);
    rd(r_prot, 32'h0000_0001);
    wr(r_ld, 32'h0000_0007);
    rd(r_ld, 32'h0000_0003);
    wr(r_prot, 32'h1ACC_E551);
    rd(r_prot, 32'h0000_0000);
    wr(r_ld, 32'h0000_0001);
    rd(r_ld, 32'h0000_0001);
    $display("lock test done");
  endtask
  // a second zero with the flag standing only reboots once the gate is open
  task automatic t_reboot();
    tick(4);
    chk(32'(reset_cycles), 32'h0000_0000);
    wr(r_ctl, 32'h0000_0003);
    tick(2);
    chk(32'(reset_cycles), 32'h0000_0001);
    chk(32'(orphan_resets), 32'h0000_0000);
    $display("reboot test done");
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_reset();
    t_count();
    t_ack();
    t_gate();
    t_lock();
    t_reboot();
    test_done();
  end
  initial begin
    repeat (4000) @(posedge core_clk);
    fails++;
    test_done();
  end
endmodule
`default_nettype wire
